// ### src/rso_reset_ctrl.sv
// rso_reset_ctrl: drives the reset output toward the microcontroller
// and carries out the software reset requested over the serial port.
// assumes the serial port shifter lives elsewhere and presents the
// decoded mode field, a write strobe and the chip-select pin level.
//
// Summary of operation
// [RULE1] a reset cause drives reset output low after the filter time
// [RULE2] reset stays low while cause persists plus the reset delay time
// [RULE3] at power-up hold reset low until regulator rises, then delay
// [RULE4] a watchdog failure also asserts the reset output
// [RULE5] undervoltage threshold selectable by a setting, defaulting to falling threshold
// [RULE6] reset only driven low with regulator at least 1V and battery OK
// [RULE7] mode field written 11 requests soft reset, returning to init state
// [RULE8] soft reset restores all settings to their defaults
// [RULE9] a setting chooses whether soft reset asserts the reset output
// [RULE10] soft reset ignored outside normal and stop states
// [RULE11] watchdog reset enters restart or fail-safe and counts failures
// [RULE12] a write takes effect only when chip select returns high
// [RULE13] filter and delay are counters; new cause restarts the delay
`timescale 1ns/1ns
`default_nettype none
module rso_reset_ctrl #(
	parameter int DELAY_CYCLES = rso_pkg::DELAY_CYCLES
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	// analog comparator levels, asynchronous to the clock
	input wire logic i_main_regulator_output_ok,
	input wire logic [3:0] i_undervoltage_threshold_ok,
	input wire logic i_main_regulator_output_above_1v,
	input wire logic i_battery_supply_above_por,
	// watchdog failure event, same clock domain
	input wire logic i_watchdog_fail,
	// serial port write and mode requests, same clock domain except chip select, which is synchronised
	input wire logic i_spi_write,
	input wire logic i_spi_mode_valid,
	input wire logic [1:0] i_spi_mode,
	input wire logic i_spi_cfg_valid,
	input wire logic [1:0] i_spi_uv_sel,
	input wire logic i_spi_swreset_asserts_rst_out,
	input wire logic i_spi_wd_to_failsafe,
	input wire logic i_spi_csn,
	input wire logic i_mode_go_normal,
	input wire logic i_mode_go_stop,
	output logic o_reset_out_n,
	output logic o_reset_out_oe,
	output logic [2:0] o_mode,
	output logic [1:0] o_undervoltage_threshold,
	output logic o_swreset_asserts_rst_out,
	output logic [1:0] o_watchdog_failure_count,
	output logic o_settings_default
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	logic [6:0] async_in;
	logic [6:0] sync_in;
	logic csn_sync;
	logic [3:0] uv_ok;
	logic above_1v;
	logic batt_ok;
	logic reg_ok;

	// chip select travels inverted so a cleared synchroniser reads as idle high
	// and no false frame end follows reset
	assign async_in = {!i_spi_csn, i_undervoltage_threshold_ok, i_main_regulator_output_above_1v,
		i_battery_supply_above_por};

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_sync
			rso_sync u_sync (
				.i_sys_clk(i_sys_clk),
				.i_resetn(i_resetn),
				.i_async(async_in[gi]),
				.o_sync(sync_in[gi])
			);
		end
	endgenerate

	assign csn_sync = !sync_in[6];
	assign uv_ok = sync_in[5:2];
	assign above_1v = sync_in[1];
	assign batt_ok = sync_in[0];

	rso_sync u_sync_reg (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_async(i_main_regulator_output_ok),
		.o_sync(reg_ok)
	);

	// ----------------------------------------------------------------
	// pending write, committed on chip-select rising
	// ----------------------------------------------------------------
	logic csn_prev;
	logic frame_end;
	logic pend_mode;
	logic [1:0] pend_mode_val;
	logic pend_cfg;
	logic [1:0] pend_uv;
	logic pend_swro;
	logic pend_wdfs;
	logic soft_reset;
	logic power_up;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			csn_prev <= 1'b1;
		else
			csn_prev <= csn_sync;
	end

	// frames end with chip select returning high
	assign frame_end = csn_sync && !csn_prev; // [RULE12]

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pend_mode <= 1'b0;
			pend_mode_val <= 2'h0;
			pend_cfg <= 1'b0;
			pend_uv <= rso_pkg::UV_SEL_RESET;
			pend_swro <= rso_pkg::SWRESET_ASSERTS_RESET;
			pend_wdfs <= rso_pkg::WD_TO_FAILSAFE_RESET;
		end
		else
		begin
			// a write in the cycle that ends the previous frame belongs to the next one
			if (frame_end)
			begin
				pend_mode <= 1'b0;
				pend_cfg <= 1'b0;
			end
			if (i_spi_write)
			begin
				if (i_spi_mode_valid)
				begin
					pend_mode <= 1'b1;
					pend_mode_val <= i_spi_mode;
				end
				if (i_spi_cfg_valid)
				begin
					pend_cfg <= 1'b1;
					pend_uv <= i_spi_uv_sel;
					pend_swro <= i_spi_swreset_asserts_rst_out;
					pend_wdfs <= i_spi_wd_to_failsafe;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// mode state
	// ----------------------------------------------------------------
	rso_pkg::rso_mode_t mode;
	logic in_normal_or_stop;
	logic wd_to_failsafe;
	logic rst_released;

	assign in_normal_or_stop = (mode == rso_pkg::RSO_NORMAL) || (mode == rso_pkg::RSO_STOP);
	assign soft_reset = frame_end && pend_mode && (pend_mode_val == rso_pkg::MODE_SOFT_RESET)
		&& in_normal_or_stop; // [RULE7] [RULE10]

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			mode <= rso_pkg::RSO_INIT;
		else if (i_watchdog_fail && mode != rso_pkg::RSO_FAILSAFE)
			mode <= wd_to_failsafe ? rso_pkg::RSO_FAILSAFE : rso_pkg::RSO_RESTART; // [RULE11]
		else if (soft_reset)
			mode <= rso_pkg::RSO_INIT; // [RULE7]
		else
		begin
			case (mode)
				rso_pkg::RSO_INIT:
				begin
					if (i_mode_go_normal)
						mode <= rso_pkg::RSO_NORMAL;
				end
				rso_pkg::RSO_NORMAL:
				begin
					if (i_mode_go_stop)
						mode <= rso_pkg::RSO_STOP;
				end
				rso_pkg::RSO_STOP:
				begin
					if (i_mode_go_normal)
						mode <= rso_pkg::RSO_NORMAL;
				end
				rso_pkg::RSO_RESTART:
				begin
					// leaving restart happens once the reset output is released
					if (rst_released)
						mode <= rso_pkg::RSO_NORMAL;
				end
				default:
				begin
					mode <= mode;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// settings, restored to their defaults by software reset
	// ----------------------------------------------------------------
	logic [1:0] uv_sel;
	logic swro;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			uv_sel <= rso_pkg::UV_SEL_RESET; // [RULE5]
			swro <= rso_pkg::SWRESET_ASSERTS_RESET;
			wd_to_failsafe <= rso_pkg::WD_TO_FAILSAFE_RESET;
		end
		else if (soft_reset)
		begin
			uv_sel <= rso_pkg::UV_SEL_RESET; // [RULE8]
			swro <= rso_pkg::SWRESET_ASSERTS_RESET;
			wd_to_failsafe <= rso_pkg::WD_TO_FAILSAFE_RESET;
		end
		else if (frame_end && pend_cfg)
		begin
			uv_sel <= pend_uv; // [RULE5] [RULE12]
			swro <= pend_swro; // [RULE9]
			wd_to_failsafe <= pend_wdfs;
		end
	end

	// ----------------------------------------------------------------
	// watchdog failure count
	// ----------------------------------------------------------------
	logic [1:0] watchdog_failure_count_cnt;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			watchdog_failure_count_cnt <= rso_pkg::WATCHDOG_FAILURE_COUNT_RESET;
		else if (i_watchdog_fail && watchdog_failure_count_cnt < rso_pkg::WATCHDOG_FAILURE_COUNT_MAX)
			watchdog_failure_count_cnt <= watchdog_failure_count_cnt + 2'h1; // [RULE11]
		else if (soft_reset)
			watchdog_failure_count_cnt <= rso_pkg::WATCHDOG_FAILURE_COUNT_RESET; // [RULE8]
	end

	// ----------------------------------------------------------------
	// reset output timing
	// ----------------------------------------------------------------
	logic uv_cause;
	logic filt_done;
	logic filt_clear;
	logic dly_done;
	logic dly_clear;
	logic rst_low;
	logic event_hit;

	// selected threshold; power-up holds the output low until regulator rises
	assign uv_cause = !uv_ok[uv_sel] || !reg_ok; // [RULE3] [RULE5]
	assign filt_clear = !uv_cause;
	// instant causes skip the filter: watchdog and soft reset with output enabled
	assign event_hit = i_watchdog_fail || (soft_reset && swro); // [RULE4] [RULE9]

	rso_timer u_filter (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_clear(filt_clear),
		.i_run(uv_cause),
		.i_limit(rso_pkg::CNT_W'(rso_pkg::FILTER_CYCLES)),
		.o_done(filt_done)
	); // [RULE1] [RULE13]

	// filtered and instant causes restart the delay count; at power-up any cause does
	assign dly_clear = filt_done || event_hit || (rst_low && uv_cause && power_up); // [RULE13]

	rso_timer u_delay (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_clear(dly_clear),
		.i_run(rst_low),
		.i_limit(rso_pkg::CNT_W'(DELAY_CYCLES)),
		.o_done(dly_done)
	); // [RULE2] [RULE13]

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			rst_low <= 1'b1; // [RULE3]
			power_up <= 1'b1;
		end
		else if (filt_done || event_hit)
			rst_low <= 1'b1; // [RULE1] [RULE4]
		else if (rst_low && dly_done && !uv_cause)
		begin
			rst_low <= 1'b0; // [RULE2]
			power_up <= 1'b0;
		end
	end

	assign rst_released = !rst_low;

	// the pin has a pull-up; active drive needs enough supply
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			o_reset_out_oe <= 1'b0;
		else
			o_reset_out_oe <= rst_low && above_1v && batt_ok; // [RULE6]
	end

	assign o_reset_out_n = 1'b0;
	assign o_mode = mode;
	assign o_undervoltage_threshold = uv_sel;
	assign o_swreset_asserts_rst_out = swro;
	assign o_watchdog_failure_count = watchdog_failure_count_cnt;
	assign o_settings_default = soft_reset; // [RULE8]
endmodule : rso_reset_ctrl
`default_nettype wire

// ### src/rso_pkg.sv
// rso_pkg: constants shared by the reset output and soft reset block
// assumes a 20 MHz system clock from the internal oscillator
package rso_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	// reset filter time and reset delay time, in microseconds
	localparam int RESET_FILTER_TIME_US = 10;
	localparam int RESET_DELAY_TIME_US = 10000;
	localparam int FILTER_CYCLES_RAW = (RESET_FILTER_TIME_US * (CLK_HZ / 1000000));
	localparam int FILTER_CYCLES = (FILTER_CYCLES_RAW < 1) ? 1 : FILTER_CYCLES_RAW;
	localparam int DELAY_CYCLES_RAW = (RESET_DELAY_TIME_US * (CLK_HZ / 1000000));
	localparam int DELAY_CYCLES = (DELAY_CYCLES_RAW < 1) ? 1 : DELAY_CYCLES_RAW;
	localparam int CNT_W = 24;

	// ----------------------------------------------------------------
	// modes and commands
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
	localparam logic [1:0] WATCHDOG_FAILURE_COUNT_MAX = 2'h2;
	localparam logic [1:0] WATCHDOG_FAILURE_COUNT_RESET = 2'h0;
	localparam logic [1:0] UV_SEL_RESET = 2'h0;
	localparam logic SWRESET_ASSERTS_RESET = 1'b1;
	localparam logic WD_TO_FAILSAFE_RESET = 1'b0;

	typedef enum logic [2:0] {
		RSO_INIT = 3'h0,
		RSO_NORMAL = 3'h1,
		RSO_STOP = 3'h3,
		RSO_RESTART = 3'h2,
		RSO_FAILSAFE = 3'h6
	} rso_mode_t;
endpackage : rso_pkg

// ### src/rso_sync.sv
// rso_sync: two flip-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to i_sys_clk
`timescale 1ns/1ns
`default_nettype none
module rso_sync (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_async,
	output logic o_sync
);
	logic stage1;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			stage1 <= 1'b0;
			o_sync <= 1'b0;
		end
		else
		begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end
endmodule : rso_sync
`default_nettype wire

// ### src/rso_timer.sv
// rso_timer: counts up while enabled, flags when the count is reached
// assumes the limit is stable; clearing restarts from zero
`timescale 1ns/1ns
`default_nettype none
module rso_timer (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_clear,
	input wire logic i_run,
	input wire logic [rso_pkg::CNT_W-1:0] i_limit,
	output logic o_done
);
	logic [rso_pkg::CNT_W-1:0] count;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			count <= '0;
		else if (i_clear)
			count <= '0;
		else if (i_run && count < i_limit)
			count <= count + 1'b1;
	end

	assign o_done = (count >= i_limit) && !i_clear;
endmodule : rso_timer
`default_nettype wire

// ### verif/rso_reset_ctrl_checker.sv
// rso_reset_ctrl_checker: timing checks on the reset output block
// assumes the fixed filter of rso_pkg and the delay of the instance
`timescale 1ns/1ns
`default_nettype none
module rso_reset_ctrl_checker #(
	parameter int DELAY_CYCLES = 20
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_main_regulator_output_ok,
	input wire logic [3:0] i_undervoltage_threshold_ok,
	input wire logic i_main_regulator_output_above_1v,
	input wire logic i_battery_supply_above_por,
	input wire logic i_watchdog_fail,
	input wire logic o_reset_out_n,
	input wire logic o_reset_out_oe,
	input wire logic [2:0] o_mode,
	input wire logic [1:0] o_undervoltage_threshold,
	input wire logic o_swreset_asserts_rst_out,
	input wire logic [1:0] o_watchdog_failure_count,
	input wire logic o_settings_default
);
	// ----------------------------------------------------------------
	// run lengths of low and healthy supply
	// ----------------------------------------------------------------
	logic [7:0] low_cnt;
	logic [7:0] ok_cnt;
	logic sup;
	assign sup = i_main_regulator_output_above_1v && i_battery_supply_above_por;
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			low_cnt <= 8'h0;
			ok_cnt <= 8'h0;
		end
		else
		begin
			low_cnt <= (i_undervoltage_threshold_ok != 4'h0) ? 8'h0 : low_cnt + 8'(low_cnt != 8'hff);
			ok_cnt <= (i_main_regulator_output_ok && i_undervoltage_threshold_ok == 4'hf) ?
				ok_cnt + 8'(ok_cnt != 8'hff) : 8'h0;
		end
	end
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_resetn);
	a_drive_low: assert property (o_reset_out_n == 1'b0)
		else $error("reset drive value not low");
	a_uv_asserts: assert property (low_cnt >= 8'hd2 && sup |-> o_reset_out_oe)
		else $error("undervoltage past filter without reset");
	a_supply_gate: assert property (!sup [*4] |-> !o_reset_out_oe)
		else $error("reset driven without supply");
	a_release_delay: assert property ($fell(o_reset_out_oe) && sup |-> ok_cnt >= DELAY_CYCLES)
		else $error("reset released early");
	a_wd_asserts: assert property (i_watchdog_fail && sup && o_mode == rso_pkg::RSO_NORMAL
		|-> ##[1:3] o_reset_out_oe)
		else $error("watchdog failure without reset");
	a_wd_count: assert property (i_watchdog_fail && o_mode == rso_pkg::RSO_NORMAL
		|=> o_watchdog_failure_count == $past(o_watchdog_failure_count) + 2'h1)
		else $error("watchdog failure not counted");
	a_wd_mode: assert property (i_watchdog_fail && o_mode == rso_pkg::RSO_NORMAL
		|-> ##[1:2] (o_mode == rso_pkg::RSO_RESTART || o_mode == rso_pkg::RSO_FAILSAFE))
		else $error("watchdog failure did not leave normal");
	a_swr_state: assert property ($rose(o_settings_default) |-> $past(o_mode) == rso_pkg::RSO_NORMAL
		|| $past(o_mode) == rso_pkg::RSO_STOP)
		else $error("soft reset outside normal or stop");
	a_swr_default: assert property (o_settings_default |=> o_mode == rso_pkg::RSO_INIT
		&& o_undervoltage_threshold == 2'h0 && o_swreset_asserts_rst_out)
		else $error("soft reset left settings");
	a_swr_pulse: assert property (o_settings_default && $past(o_swreset_asserts_rst_out) && sup
		|-> ##[0:2] o_reset_out_oe)
		else $error("soft reset did not pulse reset");
	a_swr_quiet: assert property (o_settings_default && !$past(o_swreset_asserts_rst_out)
		|-> !o_reset_out_oe [*3])
		else $error("soft reset pulsed reset while disabled");
	c_soft_reset: cover property (o_settings_default);
	c_restart: cover property (o_mode == rso_pkg::RSO_RESTART);
	c_failsafe: cover property (o_mode == rso_pkg::RSO_FAILSAFE);
endmodule : rso_reset_ctrl_checker
bind rso_reset_ctrl rso_reset_ctrl_checker #(.DELAY_CYCLES(DELAY_CYCLES)) chk_u (.*);
`default_nettype wire

// ### verif/rso_mcu_model.sv
// rso_mcu_model: microcontroller side issuing serial port frames
// assumes the bench calls frame from its own process
`timescale 1ns/1ns
`default_nettype none
module rso_mcu_model (
	input wire logic i_sys_clk,
	output logic o_spi_write,
	output logic o_spi_mode_valid,
	output logic [1:0] o_spi_mode,
	output logic o_spi_cfg_valid,
	output logic [1:0] o_spi_uv_sel,
	output logic o_spi_swr,
	output logic o_spi_fs,
	output logic o_spi_csn
);
	initial
	begin
		{o_spi_write, o_spi_mode_valid, o_spi_mode, o_spi_cfg_valid} = 5'h0;
		{o_spi_uv_sel, o_spi_swr, o_spi_fs} = 4'h0;
		o_spi_csn = 1'b1;
	end
	task frame(input logic mv, input logic [1:0] m, input logic cv, input logic [1:0] uv,
		input logic swr, input logic fs);
		@(posedge i_sys_clk);
		o_spi_csn <= 1'b0;
		@(posedge i_sys_clk);
		o_spi_write <= 1'b1;
		o_spi_mode_valid <= mv;
		o_spi_mode <= m;
		o_spi_cfg_valid <= cv;
		{o_spi_uv_sel, o_spi_swr, o_spi_fs} <= {uv, swr, fs};
		@(posedge i_sys_clk);
		// fields mean nothing past the strobe, so they are scrambled
		{o_spi_write, o_spi_mode_valid, o_spi_cfg_valid} <= 3'h0;
		{o_spi_mode, o_spi_uv_sel, o_spi_swr, o_spi_fs} <= ~{m, uv, swr, fs};
		repeat (2) @(posedge i_sys_clk);
		o_spi_csn <= 1'b1;
	endtask : frame
endmodule : rso_mcu_model
`default_nettype wire

// ### verif/rso_reset_ctrl_tb.sv
// rso_reset_ctrl_tb: scenario bench for the reset output block
// assumes a release delay shortened to 20 cycles
`timescale 1ns/1ns
`default_nettype none
module rso_reset_ctrl_tb;
	localparam int DLY = 20;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic reg_ok = 1'b0;
	logic [3:0] thr_ok = 4'h0;
	logic sup = 1'b1;
	logic bat = 1'b1;
	logic wd = 1'b0;
	logic go_n = 1'b0;
	logic go_s = 1'b0;
	logic spi_w, spi_mv, spi_cv, spi_swr, spi_fs, spi_csn, oe, rn, swr, sdef;
	logic [1:0] spi_m, spi_uv, uv, wdc;
	logic [2:0] mode;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	always #25 i_sys_clk = ~i_sys_clk;
	rso_reset_ctrl #(
		.DELAY_CYCLES(DLY)
	) dut_u (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_main_regulator_output_ok(reg_ok),
		.i_undervoltage_threshold_ok(thr_ok),
		.i_main_regulator_output_above_1v(sup),
		.i_battery_supply_above_por(bat),
		.i_watchdog_fail(wd),
		.i_spi_write(spi_w),
		.i_spi_mode_valid(spi_mv),
		.i_spi_mode(spi_m),
		.i_spi_cfg_valid(spi_cv),
		.i_spi_uv_sel(spi_uv),
		.i_spi_swreset_asserts_rst_out(spi_swr),
		.i_spi_wd_to_failsafe(spi_fs),
		.i_spi_csn(spi_csn),
		.i_mode_go_normal(go_n),
		.i_mode_go_stop(go_s),
		.o_reset_out_n(rn),
		.o_reset_out_oe(oe),
		.o_mode(mode),
		.o_undervoltage_threshold(uv),
		.o_swreset_asserts_rst_out(swr),
		.o_watchdog_failure_count(wdc),
		.o_settings_default(sdef)
	);
	rso_mcu_model mcu_u (
		.i_sys_clk(i_sys_clk),
		.o_spi_write(spi_w),
		.o_spi_mode_valid(spi_mv),
		.o_spi_mode(spi_m),
		.o_spi_cfg_valid(spi_cv),
		.o_spi_uv_sel(spi_uv),
		.o_spi_swr(spi_swr),
		.o_spi_fs(spi_fs),
		.o_spi_csn(spi_csn)
	);
	task stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task tick(input int k);
		repeat (k) @(posedge i_sys_clk);
		#1;
	endtask : tick
	task wait_oe(input logic v, input int max);
		n = 0;
		while (oe !== v && n < max)
		begin
			tick(1);
			n++;
		end
	endtask : wait_oe
	// sdef is a one-cycle pulse, so every cycle is looked at
	task watch(input int k);
		n = 0;
		repeat (k)
		begin
			tick(1);
			if (sdef === 1'b1)
				n = 1;
		end
	endtask : watch
	task pulse(input int k);
		@(posedge i_sys_clk);
		{wd, go_s, go_n} <= 3'(1 << k);
		@(posedge i_sys_clk);
		{wd, go_s, go_n} <= 3'h0;
		tick(3);
	endtask : pulse
	task t_power_up;
		tick(4);
		chk("oe_power_up", 8'h1, 8'(oe));
		chk("drive_value", 8'h0, 8'(rn));
		@(posedge i_sys_clk);
		{sup, bat} <= 2'h0;
		tick(6);
		chk("oe_no_supply", 8'h0, 8'(oe));
		@(posedge i_sys_clk);
		{sup, bat} <= 2'h3;
		wait_oe(1'b1, 6);
		@(posedge i_sys_clk);
		{reg_ok, thr_ok} <= 5'h1f;
		wait_oe(1'b0, 40);
		chk("power_up_delay", 8'h1, 8'(n >= DLY && n <= DLY + 8));
		$display("test power_up done");
	endtask : t_power_up
	task t_undervoltage;
		@(posedge i_sys_clk);
		{reg_ok, thr_ok} <= 5'h0;
		tick(150);
		chk("oe_filtered", 8'h0, 8'(oe));
		wait_oe(1'b1, 80);
		tick(30);
		chk("oe_held", 8'h1, 8'(oe));
		@(posedge i_sys_clk);
		{reg_ok, thr_ok} <= 5'h1f;
		wait_oe(1'b0, 40);
		chk("uv_delay", 8'h1, 8'(n >= DLY && n <= DLY + 8));
		$display("test undervoltage done");
	endtask : t_undervoltage
	task t_soft_reset(input logic en);
		pulse(0);
		chk("mode_normal", 8'(rso_pkg::RSO_NORMAL), 8'(mode));
		mcu_u.frame(1'b0, 2'h0, 1'b1, 2'h2, en, 1'b0);
		chk("uv_pending", 8'h0, 8'(uv));
		tick(6);
		chk("uv_set", 8'h2, 8'(uv));
		chk("swr_set", 8'(en), 8'(swr));
		mcu_u.frame(1'b1, rso_pkg::MODE_SOFT_RESET, 1'b0, 2'h0, 1'b1, 1'b0);
		watch(8);
		chk("swr_done", 8'h1, 8'(n));
		chk("swr_oe", 8'(en), 8'(oe));
		chk("swr_mode", 8'(rso_pkg::RSO_INIT), 8'(mode));
		chk("swr_uv", 8'h0, 8'(uv));
		chk("swr_cfg", 8'h1, 8'(swr));
		wait_oe(1'b0, 40);
		chk("swr_delay", 8'h1, 8'(en ? (n >= DLY - 8 && n <= DLY) : (n == 0)));
		$display("test soft_reset done");
	endtask : t_soft_reset
	task t_refused;
		mcu_u.frame(1'b1, rso_pkg::MODE_SOFT_RESET, 1'b0, 2'h0, 1'b1, 1'b0);
		watch(10);
		chk("init_ignored", 8'h0, 8'(n));
		pulse(0);
		pulse(1);
		chk("mode_stop", 8'(rso_pkg::RSO_STOP), 8'(mode));
		mcu_u.frame(1'b1, rso_pkg::MODE_SOFT_RESET, 1'b0, 2'h0, 1'b1, 1'b0);
		watch(10);
		chk("stop_taken", 8'h1, 8'(n));
		wait_oe(1'b0, 40);
		chk("stop_release", 8'h0, 8'(oe));
		$display("test refused done");
	endtask : t_refused
	task t_watchdog;
		pulse(0);
		pulse(2);
		chk("oe_wd", 8'h1, 8'(oe));
		chk("mode_restart", 8'(rso_pkg::RSO_RESTART), 8'(mode));
		chk("wd_count1", 8'h1, 8'(wdc));
		wait_oe(1'b0, 40);
		tick(3);
		chk("mode_back", 8'(rso_pkg::RSO_NORMAL), 8'(mode));
		mcu_u.frame(1'b0, 2'h0, 1'b1, 2'h0, 1'b1, 1'b1);
		tick(6);
		pulse(2);
		chk("mode_failsafe", 8'(rso_pkg::RSO_FAILSAFE), 8'(mode));
		chk("wd_count2", 8'h2, 8'(wdc));
		$display("test watchdog done");
	endtask : t_watchdog
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			stop_test;
		end
	end
	initial
	begin
		repeat (12) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		t_power_up;
		t_undervoltage;
		t_soft_reset(1'b1);
		t_soft_reset(1'b0);
		t_refused;
		t_watchdog;
		stop_test;
	end
endmodule : rso_reset_ctrl_tb
`default_nettype wire
